/* logic/fisp_slave.v */
/*
 * Two-wire serial slave port that presents an on-chip byte array as a
 * serial EEPROM: condition detection, address match, byte write, reads.
 * Assumes scl_in and sda_in are the resolved wire levels of open-drain
 * lines, and that the pins for device select and write protect are static.
 */
`timescale 1ns/1ps
`include "fisp_map.vh"

module fisp_slave #(
	parameter MEM_DEPTH     = 1024,
	parameter WP_UPPER_ONLY = 0
) (
	input  wire        clk_sys,
	input  wire        rst_n,
	input  wire        scl_in,
	input  wire        sda_in,
	input  wire        device_select_bit2,
	input  wire        device_select_bit1,
	input  wire        device_select_bit0,
	input  wire        wp,
	output wire        scl_out,
	output wire        scl_oe,
	output wire        sda_out,
	output wire        sda_oe,
	output wire        bus_busy,
	output wire        write_busy
);

	// Integer forms are cut to the datapath widths on purpose below.
	localparam integer           MASK_INT  = MEM_DEPTH - 1;
	localparam integer           HALF_INT  = MEM_DEPTH / 2;
	localparam integer           WR_INT    = `FISP_WR_CYCLES;
	localparam [`FISP_AW-1:0]    ADDR_MASK = MASK_INT[`FISP_AW-1:0];
	localparam [`FISP_AW-1:0]    HALF_ADDR = HALF_INT[`FISP_AW-1:0];
	localparam [`FISP_CNT_W-1:0] WR_COUNT  = WR_INT[`FISP_CNT_W-1:0];

	// State codes of the protocol engine.
	localparam [2:0]             ST_IDLE   = `FISP_ST_IDLE;
	localparam [2:0]             ST_ADDR   = `FISP_ST_ADDR;
	localparam [2:0]             ST_WADDR  = `FISP_ST_WADDR;
	localparam [2:0]             ST_WDATA  = `FISP_ST_WDATA;
	localparam [2:0]             ST_ACK    = `FISP_ST_ACK;
	localparam [2:0]             ST_RDATA  = `FISP_ST_RDATA;
	localparam [2:0]             ST_RACK   = `FISP_ST_RACK;
	localparam [2:0]             ST_WAIT   = `FISP_ST_WAIT;

	reg  [1:0]                 line_s1_ff;
	reg  [1:0]                 line_s2_ff;
	reg  [1:0]                 line_f_ff;
	reg  [1:0]                 line_p_ff;
	reg  [`FISP_FILT_W-1:0]    filt_cnt_ff [0:1];
	reg  [3:0]                 pin_s1_ff;
	reg  [3:0]                 pin_s2_ff;

	reg  [2:0]                 state_ff;
	reg  [2:0]                 ret_state_ff;
	reg  [3:0]                 bit_cnt_ff;
	reg  [7:0]                 rx_sh_ff;
	reg  [7:0]                 tx_sh_ff;
	reg  [`FISP_AW-1:0]        addr_ff;
	reg  [7:0]                 wdata_ff;
	reg  [`FISP_AW-1:0]        waddr_ff;
	reg                        pend_ff;
	reg                        mack_ff;
	reg  [`FISP_CNT_W-1:0]     wr_cnt_ff;
	reg                        wr_busy_ff;
	reg                        bus_busy_ff;
	reg                        sda_oe_ff;
	reg                        sda_out_ff;
	reg                        scl_oe_ff;
	reg                        scl_out_ff;

	reg  [7:0]                 mem [0:`FISP_DEPTH_MAX-1];

	wire                       scl_f;
	wire                       sda_f;
	wire                       scl_rise;
	wire                       scl_fall;
	wire                       start_det;
	wire                       stop_det;
	wire                       ds2;
	wire                       ds1;
	wire                       ds0;
	wire                       wp_s;
	wire                       sel_match;
	wire                       addr_match;
	wire [`FISP_AW-1:0]        hi_addr;
	wire [`FISP_AW-1:0]        full_addr;
	wire                       protected_hit;
	wire [7:0]                 rd_byte;

	// Two-stage synchronisers followed by a stability filter per line.
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_line
			always @(posedge clk_sys or negedge rst_n) begin
				if (!rst_n) begin
					line_s1_ff[gi]  <= 1'b1;
					line_s2_ff[gi]  <= 1'b1;
					line_f_ff[gi]   <= 1'b1;
					line_p_ff[gi]   <= 1'b1;
					filt_cnt_ff[gi] <= {`FISP_FILT_W{1'b0}};
				end else begin
					line_s1_ff[gi] <= (gi == `FISP_LINE_SCL) ? scl_in : sda_in;
					line_s2_ff[gi] <= line_s1_ff[gi];
					line_p_ff[gi]  <= line_f_ff[gi];
					if (line_s2_ff[gi] == line_f_ff[gi]) begin
						filt_cnt_ff[gi] <= {`FISP_FILT_W{1'b0}};
					end else if (filt_cnt_ff[gi] == `FISP_FILT_LEN - 3'h1) begin
						line_f_ff[gi]   <= line_s2_ff[gi];
						filt_cnt_ff[gi] <= {`FISP_FILT_W{1'b0}};
					end else begin
						filt_cnt_ff[gi] <= filt_cnt_ff[gi] + 3'h1;
					end
				end
			end
		end
	endgenerate

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pin_s1_ff <= 4'h0;
			pin_s2_ff <= 4'h0;
		end else begin
			pin_s1_ff <= {wp, device_select_bit2, device_select_bit1, device_select_bit0};
			pin_s2_ff <= pin_s1_ff;
		end
	end

	assign wp_s = pin_s2_ff[3];
	assign ds2  = pin_s2_ff[2];
	assign ds1  = pin_s2_ff[1];
	assign ds0  = pin_s2_ff[0];

	assign scl_f     = line_f_ff[`FISP_LINE_SCL];
	assign sda_f     = line_f_ff[`FISP_LINE_SDA];
	assign scl_rise  = scl_f & ~line_p_ff[`FISP_LINE_SCL];
	assign scl_fall  = ~scl_f & line_p_ff[`FISP_LINE_SCL];
	// Both lines are filtered alike, so a data edge with clock high is a condition.
	assign start_det = scl_f & line_p_ff[`FISP_LINE_SCL] & line_p_ff[`FISP_LINE_SDA] & ~sda_f;
	assign stop_det  = scl_f & line_p_ff[`FISP_LINE_SCL] & ~line_p_ff[`FISP_LINE_SDA] & sda_f;

	// Select slots that carry byte address bits are not compared.
	assign sel_match = (rx_sh_ff[`FISP_SA_DS2] == ds2) &
		((MEM_DEPTH >= `FISP_DEPTH_8K) | (rx_sh_ff[`FISP_SA_DS1] == ds1)) &
		((MEM_DEPTH >= `FISP_DEPTH_4K) | (rx_sh_ff[`FISP_SA_DS0] == ds0));
	assign addr_match = (rx_sh_ff[`FISP_SA_PREFIX_HI:`FISP_SA_PREFIX_LO] == `FISP_ADDR_PREFIX)
		& sel_match;
	assign hi_addr = {rx_sh_ff[`FISP_SA_DS1], rx_sh_ff[`FISP_SA_DS0], 8'h00}
		& ADDR_MASK;
	assign full_addr = {addr_ff[`FISP_AW-1:8], rx_sh_ff} & ADDR_MASK;
	assign protected_hit = wp_s & ((WP_UPPER_ONLY == 0) | (addr_ff >= HALF_ADDR));
	assign rd_byte = mem[addr_ff];

	// Internal write happens after stop and holds the busy counter.
	always @(posedge clk_sys) begin
		if (stop_det & pend_ff & ~wr_busy_ff) begin
			mem[waddr_ff] <= wdata_ff;
		end
	end

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wr_busy_ff <= 1'b0;
			wr_cnt_ff  <= {`FISP_CNT_W{1'b0}};
		end else if (stop_det & pend_ff & ~wr_busy_ff) begin
			wr_busy_ff <= 1'b1;
			wr_cnt_ff  <= WR_COUNT;
		end else if (wr_busy_ff) begin
			if (wr_cnt_ff == {{(`FISP_CNT_W-1){1'b0}}, 1'b1}) begin
				wr_busy_ff <= 1'b0;
			end
			wr_cnt_ff <= wr_cnt_ff - {{(`FISP_CNT_W-1){1'b0}}, 1'b1};
		end
	end

	// Bus busy follows start and stop; a repeated start leaves it set.
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			bus_busy_ff <= 1'b0;
		end else if (start_det) begin
			bus_busy_ff <= 1'b1;
		end else if (stop_det) begin
			bus_busy_ff <= 1'b0;
		end
	end

	// Protocol engine: sample on clock rise, change data only on clock fall.
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_ff     <= ST_IDLE;
			ret_state_ff <= ST_IDLE;
			bit_cnt_ff   <= 4'h0;
			rx_sh_ff     <= 8'h00;
			tx_sh_ff     <= 8'h00;
			addr_ff      <= {`FISP_AW{1'b0}};
			waddr_ff     <= {`FISP_AW{1'b0}};
			wdata_ff     <= 8'h00;
			pend_ff      <= 1'b0;
			mack_ff      <= 1'b0;
			sda_oe_ff    <= 1'b0;
		end else if (stop_det) begin
			state_ff  <= ST_IDLE;
			sda_oe_ff <= 1'b0;
			pend_ff   <= 1'b0;
		end else if (start_det) begin
			// A start during the internal write is parked until the next stop, or until a start that comes after the write ends.
			sda_oe_ff  <= 1'b0;
			bit_cnt_ff <= 4'h0;
			pend_ff    <= 1'b0;
			state_ff   <= wr_busy_ff ? ST_WAIT : ST_ADDR;
		end else begin
			case (state_ff)
				ST_ADDR, ST_WADDR, ST_WDATA: begin
					if (scl_rise) begin
						rx_sh_ff   <= {rx_sh_ff[6:0], sda_f};
						bit_cnt_ff <= bit_cnt_ff + 4'h1;
					end else if (scl_fall & (bit_cnt_ff == `FISP_BYTE_BITS)) begin
						bit_cnt_ff <= 4'h0;
						if (state_ff == ST_ADDR) begin
							if (addr_match & ~wr_busy_ff) begin
								sda_oe_ff <= 1'b1;
								state_ff  <= ST_ACK;
								// Upper address bits come from the slave address slots.
								addr_ff   <= {hi_addr[`FISP_AW-1:8], addr_ff[7:0]};
								ret_state_ff <= rx_sh_ff[`FISP_SA_RW] ?
									ST_RDATA : ST_WADDR;
							end else begin
								state_ff <= ST_WAIT;
							end
						end else if (state_ff == ST_WADDR) begin
							addr_ff      <= full_addr;
							sda_oe_ff    <= 1'b1;
							state_ff     <= ST_ACK;
							ret_state_ff <= ST_WDATA;
						end else if (protected_hit) begin
							state_ff <= ST_WAIT;
						end else begin
							wdata_ff     <= rx_sh_ff;
							waddr_ff     <= addr_ff;
							pend_ff      <= 1'b1;
							sda_oe_ff    <= 1'b1;
							state_ff     <= ST_ACK;
							ret_state_ff <= ST_WAIT;
						end
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						state_ff <= ret_state_ff;
						if (ret_state_ff == ST_RDATA) begin
							tx_sh_ff  <= rd_byte;
							sda_oe_ff <= ~rd_byte[7];
							addr_ff   <= (addr_ff + 10'h001) & ADDR_MASK;
						end else begin
							sda_oe_ff <= 1'b0;
						end
					end
				end
				ST_RDATA: begin
					// The next bit goes out after the clock falls, never while it is high.
					if (scl_rise) begin
						bit_cnt_ff <= bit_cnt_ff + 4'h1;
					end else if (scl_fall) begin
						if (bit_cnt_ff == `FISP_BYTE_BITS) begin
							sda_oe_ff  <= 1'b0;
							bit_cnt_ff <= 4'h0;
							state_ff   <= ST_RACK;
						end else begin
							tx_sh_ff  <= {tx_sh_ff[6:0], 1'b1};
							sda_oe_ff <= ~tx_sh_ff[6];
						end
					end
				end
				ST_RACK: begin
					// A not-acknowledge from the master ends the read with the line released.
					if (scl_rise) begin
						mack_ff <= ~sda_f;
					end else if (scl_fall) begin
						if (mack_ff) begin
							tx_sh_ff  <= rd_byte;
							sda_oe_ff <= ~rd_byte[7];
							addr_ff   <= (addr_ff + 10'h001) & ADDR_MASK;
							state_ff  <= ST_RDATA;
						end else begin
							state_ff <= ST_WAIT;
						end
					end
				end
				ST_WAIT: begin
					sda_oe_ff <= 1'b0;
				end
				ST_IDLE: begin
					sda_oe_ff <= 1'b0;
				end
				default: begin
					state_ff  <= ST_IDLE;
					sda_oe_ff <= 1'b0;
				end
			endcase
		end
	end

	// The port never stretches the clock and only ever pulls lines low.
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sda_out_ff <= 1'b0;
			scl_out_ff <= 1'b0;
			scl_oe_ff  <= 1'b0;
		end else begin
			sda_out_ff <= 1'b0;
			scl_out_ff <= 1'b0;
			scl_oe_ff  <= 1'b0;
		end
	end

	assign sda_out    = sda_out_ff;
	assign sda_oe     = sda_oe_ff;
	assign scl_out    = scl_out_ff;
	assign scl_oe     = scl_oe_ff;
	assign bus_busy   = bus_busy_ff;
	assign write_busy = wr_busy_ff;

endmodule // fisp_slave

/* logic/fisp_map.vh */
/*
 * Constants for the two-wire flash slave port: timing, filter length,
 * slave address layout, state codes and line indices.
 * Assumes the including module runs from a 40 MHz system clock.
 */
`ifndef FISP_MAP_VH
`define FISP_MAP_VH

`define FISP_CLK_MHZ        40
`define FISP_WR_TIME_US     100
`define FISP_WR_CYCLES      (`FISP_WR_TIME_US * `FISP_CLK_MHZ)
`define FISP_CNT_W          12
`define FISP_FILT_LEN       3'h3
`define FISP_FILT_W         3

`define FISP_ADDR_PREFIX    4'ha
`define FISP_BYTE_BITS      4'h8
`define FISP_AW             10
`define FISP_DEPTH_MAX      1024

`define FISP_SA_PREFIX_HI   7
`define FISP_SA_PREFIX_LO   4
`define FISP_SA_DS2         3
`define FISP_SA_DS1         2
`define FISP_SA_DS0         1
`define FISP_SA_RW          0

`define FISP_DEPTH_4K       512
`define FISP_DEPTH_8K       1024

`define FISP_ST_IDLE        3'h0
`define FISP_ST_ADDR        3'h1
`define FISP_ST_WADDR       3'h2
`define FISP_ST_WDATA       3'h3
`define FISP_ST_ACK         3'h4
`define FISP_ST_RDATA       3'h5
`define FISP_ST_RACK        3'h6
`define FISP_ST_WAIT        3'h7

`define FISP_LINE_SCL       0
`define FISP_LINE_SDA       1

`endif

/* verif/fisp_slave_asserts.sv */
/* Checker for the two-wire flash slave port: drive, condition and write-cycle relations.
   Assumes it is bound to fisp_slave and the bus lines have pull-ups. */
`timescale 1ns/1ps
`include "fisp_map.vh"
module fisp_slave_asserts (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic scl_out,
	input wire logic scl_oe,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic bus_busy,
	input wire logic write_busy
);
	logic [12:0] busy_cnt_ff;
	logic [12:0] nxt_busy_cnt;
	assign nxt_busy_cnt = write_busy ? busy_cnt_ff + 13'h1 : 13'h0;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			busy_cnt_ff <= 13'h0;
		end else begin
			busy_cnt_ff <= nxt_busy_cnt;
		end
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	property p_od_only; !scl_oe && !scl_out && !sda_out; endproperty
	a_od_only: assert property (p_od_only)
		else $error("line driven high or clock held");
	property p_start_seen; $rose(bus_busy) |-> scl_in && !sda_in && !$past(sda_in, 3); endproperty
	a_start_seen: assert property (p_start_seen)
		else $error("busy without a settled start");
	property p_stop_frees; $fell(bus_busy) |-> scl_in && sda_in && $past(scl_in, 4); endproperty
	a_stop_frees: assert property (p_stop_frees)
		else $error("bus freed without stop");
	property p_drive_in_frame; sda_oe |-> bus_busy; endproperty
	a_drive_in_frame: assert property (p_drive_in_frame)
		else $error("data pulled outside a transfer");
	property p_change_low; $changed(sda_oe) |-> !scl_in; endproperty
	a_change_low: assert property (p_change_low)
		else $error("data changed while clock high");
	property p_quiet_write; write_busy |-> !sda_oe; endproperty
	a_quiet_write: assert property (p_quiet_write)
		else $error("answered during write cycle");
	property p_write_after_stop; $rose(write_busy) |-> !bus_busy && sda_in && scl_in; endproperty
	a_write_after_stop: assert property (p_write_after_stop)
		else $error("write began before stop");
	property p_write_time; $fell(write_busy) |-> busy_cnt_ff == `FISP_WR_CYCLES; endproperty
	a_write_time: assert property (p_write_time)
		else $error("write cycle length wrong");
	property p_ack_holds; $rose(scl_in) && sda_oe |=> sda_oe [*4]; endproperty
	a_ack_holds: assert property (p_ack_holds)
		else $error("acknowledge not held over clock high");
	c_ack: cover property ($rose(sda_oe));
	c_write: cover property ($rose(write_busy));
	c_stop: cover property ($fell(bus_busy));
endmodule // fisp_slave_asserts
bind fisp_slave fisp_slave_asserts u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .scl_in(scl_in),
	.sda_in(sda_in), .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out),
	.sda_oe(sda_oe), .bus_busy(bus_busy), .write_busy(write_busy));

/* verif/fisp_master_model.sv */
/* Behavioural two-wire bus master that only pulls lines low or releases them.
   Assumes pull-ups resolve released lines high in the bench. */
`timescale 1ns/1ps
module fisp_master_model (
	input wire logic clk_sys,
	input wire logic sda,
	output logic     scl_low,
	output logic     sda_low
);
	initial begin
		scl_low = 1'b0;
		sda_low = 1'b0;
	end
	task automatic w(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	// Data moves late in the low phase so the slave's delayed answer also lands there.
	task automatic bit_x(input logic d, output logic q);
		w(5);
		sda_low = !d;
		w(3);
		scl_low = 1'b0;
		w(4);
		q = sda;
		w(4);
		scl_low = 1'b1;
	endtask
	task automatic start();
		w(5);
		sda_low = 1'b0;
		w(3);
		scl_low = 1'b0;
		w(8);
		sda_low = 1'b1;
		w(8);
		scl_low = 1'b1;
	endtask
	task automatic stop();
		w(5);
		sda_low = 1'b1;
		w(3);
		scl_low = 1'b0;
		w(8);
		sda_low = 1'b0;
		w(12);
	endtask
	task automatic byte_x(input logic [8:0] d, output logic [8:0] q);
		for (int i = 8; i >= 0; i--) begin
			bit_x(d[i], q[i]);
		end
	endtask
	task automatic glitch();
		sda_low = 1'b1;
		w(2);
		sda_low = 1'b0;
		w(12);
	endtask
endmodule // fisp_master_model

/* verif/fisp_slave_tb.sv */
/* Self-checking bench for fisp_slave with random straps, addresses and data.
   Assumes the master model and the bound checker are compiled alongside. */
`timescale 1ns/1ps
module fisp_slave_tb;
	logic        clk_sys = 1'b0;
	logic        rst_n = 1'b0;
	logic        wp = 1'b0;
	logic [2:0]  sel = 3'h0;
	logic        scl_oe, scl_out, sda_oe, sda_out, bus_busy, write_busy, scl_low, sda_low;
	logic        scl, sda;
	logic [31:0] seed = 32'h00009853;
	int          fail_count = 0;
	int          n_compared = 0;
	int          cyc = 0;
	logic [7:0]  mem [0:1023];
	logic [8:0]  q;
	logic [9:0]  a;
	logic [7:0]  d;
	always #12.5 clk_sys = ~clk_sys;
	assign scl = ~(scl_oe | scl_low);
	assign sda = ~(sda_oe | sda_low);
	fisp_slave u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .scl_in(scl), .sda_in(sda),
		.device_select_bit2(sel[2]), .device_select_bit1(sel[1]),
		.device_select_bit0(sel[0]), .wp(wp), .scl_out(scl_out), .scl_oe(scl_oe),
		.sda_out(sda_out), .sda_oe(sda_oe), .bus_busy(bus_busy), .write_busy(write_busy));
	fisp_master_model u_mst (.clk_sys(clk_sys), .sda(sda), .scl_low(scl_low), .sda_low(sda_low));
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	function automatic logic [7:0] sa(input logic [9:0] adr, input logic rw);
		return {4'ha, sel[2], adr[9:8], rw};
	endfunction
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic tally_and_finish();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] s, input logic [7:0] ba, input logic [7:0] dat,
			input logic [2:0] acks);
		u_mst.start();
		chk("bus busy", 8'(bus_busy), 8'h1);
		u_mst.byte_x({s, 1'b1}, q);
		chk("slave address ack", 8'(q[0]), 8'(!acks[2]));
		u_mst.byte_x({ba, 1'b1}, q);
		chk("byte address ack", 8'(q[0]), 8'(!acks[1]));
		u_mst.byte_x({dat, 1'b1}, q);
		chk("data ack", 8'(q[0]), 8'(!acks[0]));
		u_mst.stop();
		chk("bus free", 8'(bus_busy), 8'h0);
		chk("line drive", {5'h0, scl_oe, scl_out, sda_out}, 8'h00);
	endtask
	task automatic rd(input logic [9:0] adr);
		u_mst.start();
		u_mst.byte_x({sa(adr, 1'b0), 1'b1}, q);
		u_mst.byte_x({adr[7:0], 1'b1}, q);
		u_mst.start();
		u_mst.byte_x({sa(adr, 1'b1), 1'b1}, q);
		chk("read address ack", 8'(q[0]), 8'h0);
		u_mst.byte_x({8'hff, 1'b0}, q);
		chk("read byte 0", q[8:1], mem[adr]);
		u_mst.byte_x({8'hff, 1'b1}, q);
		chk("read byte 1", q[8:1], mem[10'(adr + 10'h1)]);
		u_mst.stop();
	endtask
	task automatic wait_idle();
		for (int k = 0; k < 5000 && write_busy !== 1'b0; k++) begin
			@(negedge clk_sys);
		end
		chk("write busy end", 8'(write_busy), 8'h0);
	endtask
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 30000) begin
			fail_count++;
			tally_and_finish();
		end
	end
	initial begin
		seed = xs(seed);
		sel = seed[2:0];
		a = seed[17:8];
		repeat (10) @(negedge clk_sys);
		rst_n = 1'b1;
		u_mst.w(12);
		u_mst.glitch();
		chk("glitch busy", 8'(bus_busy), 8'h0);
		for (int k = 0; k < 2; k++) begin
			seed = xs(seed);
			d = seed[7:0];
			mem[10'(a + k)] = d;
			wr(sa(10'(a + k), 1'b0), 8'(a + k), d, 3'h7);
			chk("write busy", 8'(write_busy), 8'h1);
			wr(sa(a, 1'b0), a[7:0], ~d, 3'h0);
			wait_idle();
		end
		rd(a);
		wp = 1'b1;
		wr(sa(a, 1'b0), a[7:0], ~mem[a], 3'h6);
		chk("protected busy", 8'(write_busy), 8'h0);
		wp = 1'b0;
		wr({4'h5, sel[2], a[9:8], 1'b0}, a[7:0], 8'h00, 3'h0);
		wr({4'ha, ~sel[2], a[9:8], 1'b0}, a[7:0], 8'h00, 3'h0);
		rd(a);
		tally_and_finish();
	end
endmodule // fisp_slave_tb
